// ### shared/bccc_pkg.sv
// Purpose: Constants for the back-channel capability and rate block
// Assumes: 8-bit register addresses and data
// Notes: Offsets of control, direction and status are local choices
package bccc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CAP_ONE = 8'h20;
  localparam logic [7:0] ADDR_CAP_TWO = 8'h21;
  localparam logic [7:0] ADDR_RATE_SEL = 8'h23;
  localparam logic [7:0] ADDR_OSC_DIV = 8'h32;
  localparam logic [7:0] ADDR_CTRL = 8'h40;
  localparam logic [7:0] ADDR_DIR = 8'h41;
  localparam logic [7:0] ADDR_STATUS = 8'h42;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_MODE_LOW = 6;
  localparam int BIT_CRC_EN = 3;
  localparam int BIT_CHK_ERR = 2;
  localparam int BIT_RATE_DBL = 2;
  localparam int BIT_FAST = 0;
  localparam int BIT_SPLIT = 1;
  localparam int BIT_HOLD = 2;
  localparam int BIT_CHK_EN = 3;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [3:0] OSC_DIV_RESET = 4'h9;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_FAST_ONE = 3'h1;
  localparam logic [2:0] MODE_FAST_TWO = 3'h2;
  localparam logic [2:0] MODE_FAST_FOUR = 3'h3;
  localparam logic [2:0] MODE_RSVD_A = 3'h4;
  localparam logic [2:0] MODE_RSVD_B = 3'h5;
  localparam logic [2:0] MODE_SPI_FWD = 3'h6;
  localparam logic [2:0] MODE_SPI_REV = 3'h7;
  // Tick divisor scale: clk stands for the 200 MHz reference
  localparam logic [5:0] SCALE_NORMAL = 6'h04;
endpackage

// ### hdl/bccc_regs.sv
// Purpose: Sink capability bank two, back-channel rate and signal routing
// Assumes: Register port strobes one cycle long, read data one cycle later
// Notes: clk stands for the 200 MHz reference of the back-channel divider
`timescale 1ns/1ps

module bccc_regs #(
  parameter int NSIG = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic single_link,
  input wire logic rx_lock,
  input wire logic cap_load,
  input wire logic [7:0] cap_one_in,
  input wire logic [7:0] cap_two_in,
  input wire logic pixel_sum_bad,
  input wire logic [NSIG-1:0] gpio_pin_in,
  input wire logic [NSIG-1:0] sec_gpio_pin_in,
  input wire logic [NSIG-1:0] port0_rev_in,
  input wire logic [NSIG-1:0] port1_rev_in,
  output logic [NSIG-1:0] port0_fwd_out,
  output logic [NSIG-1:0] port1_fwd_out,
  output logic [NSIG-1:0] gpio_pin_out,
  output logic [NSIG-1:0] gpio_pin_oe,
  output logic [NSIG-1:0] sec_gpio_pin_out,
  output logic [NSIG-1:0] sec_gpio_pin_oe,
  output logic [2:0] fast_mode_code,
  output logic fast_mode_ok,
  output logic enhanced_crc_enable,
  output logic back_bit_tick,
  output logic back_rate_bad
);

  // ----------------------------------------
  // Mode decode helper
  // ----------------------------------------
  function automatic logic [NSIG-1:0] sig_mask(input logic [2:0] code);
    sig_mask = '1;
    if (code == bccc_pkg::MODE_FAST_ONE) begin
      sig_mask = NSIG'(1);
    end else if (code == bccc_pkg::MODE_FAST_TWO) begin
      sig_mask = NSIG'(3);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic mode_low_ff;
  logic [1:0] fast_ctrl_mode_upper_ff;
  logic crc_ff;
  logic chk_err_ff;
  logic rate_dbl_ff;
  logic [3:0] osc_div_ff;
  logic [3:0] ctrl_ff;
  logic [7:0] dir_ff;
  logic [7:0] rdata_ff;
  logic [5:0] cnt_ff;
  logic [5:0] cfg_ff;
  logic tick_ff;
  logic [NSIG-1:0] p0_ff, p1_ff, g_ff, s_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_cap1 = reg_wr && (reg_addr == bccc_pkg::ADDR_CAP_ONE);
  wire wr_cap2 = reg_wr && (reg_addr == bccc_pkg::ADDR_CAP_TWO);
  wire wr_rate = reg_wr && (reg_addr == bccc_pkg::ADDR_RATE_SEL);
  wire wr_div = reg_wr && (reg_addr == bccc_pkg::ADDR_OSC_DIV);
  wire wr_ctrl = reg_wr && (reg_addr == bccc_pkg::ADDR_CTRL);
  wire wr_dir = reg_wr && (reg_addr == bccc_pkg::ADDR_DIR);
  wire back_fast_mode = ctrl_ff[bccc_pkg::BIT_FAST];
  wire splitter_on = ctrl_ff[bccc_pkg::BIT_SPLIT];
  wire hold_caps = ctrl_ff[bccc_pkg::BIT_HOLD];
  wire chk_enable = ctrl_ff[bccc_pkg::BIT_CHK_EN];
  wire link_load = cap_load && rx_lock && !hold_caps;

  // ----------------------------------------
  // Capability fields
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_low_ff <= 1'b0;
      fast_ctrl_mode_upper_ff <= 2'h0;
      crc_ff <= 1'b0;
    end else if (link_load) begin
      mode_low_ff <= cap_one_in[bccc_pkg::BIT_MODE_LOW];
      fast_ctrl_mode_upper_ff <= cap_two_in[1:0];
      crc_ff <= cap_two_in[bccc_pkg::BIT_CRC_EN];
    end else begin
      if (wr_cap1) begin
        mode_low_ff <= reg_wdata[bccc_pkg::BIT_MODE_LOW];
      end
      if (wr_cap2) begin
        fast_ctrl_mode_upper_ff <= reg_wdata[1:0];
        crc_ff <= reg_wdata[bccc_pkg::BIT_CRC_EN];
      end
    end
  end

  // Sticky checksum flag; dropping the enable clears it
  wire nxt_chk_err = (pixel_sum_bad && chk_enable) || (chk_err_ff && chk_enable);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      chk_err_ff <= 1'b0;
    end else begin
      chk_err_ff <= nxt_chk_err;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rate_dbl_ff <= 1'b0;
      osc_div_ff <= bccc_pkg::OSC_DIV_RESET;
      ctrl_ff <= 4'h0;
      dir_ff <= bccc_pkg::DIR_RESET;
    end else begin
      if (wr_rate) begin
        rate_dbl_ff <= reg_wdata[bccc_pkg::BIT_RATE_DBL];
      end
      if (wr_div) begin
        osc_div_ff <= reg_wdata[3:0];
      end
      if (wr_ctrl) begin
        ctrl_ff <= reg_wdata[3:0];
      end
      if (wr_dir) begin
        dir_ff <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Mode code
  // ----------------------------------------
  wire [2:0] raw_code = {fast_ctrl_mode_upper_ff, mode_low_ff};
  wire code_rsvd = (raw_code == bccc_pkg::MODE_RSVD_A) ||
                   (raw_code == bccc_pkg::MODE_RSVD_B);
  wire code_ok = !code_rsvd && !(single_link && raw_code != bccc_pkg::MODE_NORMAL);
  wire [2:0] eff_code = code_ok ? raw_code : bccc_pkg::MODE_NORMAL;
  wire [NSIG-1:0] sec_mask = sig_mask(eff_code);

  // ----------------------------------------
  // Back-channel divider
  // ----------------------------------------
  wire [4:0] ratio_n = {1'b0, osc_div_ff} + 5'h01;
  wire odd_bad = back_fast_mode && ratio_n[0];
  wire [5:0] period = back_fast_mode ? {1'b0, ratio_n} :
                      rate_dbl_ff ? {ratio_n, 1'b0} :
                      6'({ratio_n, 2'b00});
  wire [5:0] cfg_now = {back_fast_mode, rate_dbl_ff, osc_div_ff};
  wire cfg_chg = cfg_now != cfg_ff;
  wire wrap = cnt_ff == 6'h00;
  wire [5:0] nxt_cnt = (cfg_chg || wrap) ? period - 6'h01 : cnt_ff - 6'h01;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_ff <= 6'h00;
      cfg_ff <= {2'b00, bccc_pkg::OSC_DIV_RESET};
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      cfg_ff <= cfg_now;
      tick_ff <= wrap && !cfg_chg;
    end
  end

  // ----------------------------------------
  // Signal routing
  // ----------------------------------------
  wire [NSIG-1:0] g_rev = dir_ff[NSIG-1:0];
  wire [NSIG-1:0] s_rev = dir_ff[2*NSIG-1:NSIG];
  wire [NSIG-1:0] s_use = sec_mask & {NSIG{splitter_on}};
  wire [NSIG-1:0] nxt_p0 = gpio_pin_in & ~g_rev;
  wire [NSIG-1:0] nxt_p1 = sec_gpio_pin_in & ~s_rev & s_use;
  wire [NSIG-1:0] nxt_g = port0_rev_in & g_rev;
  wire [NSIG-1:0] nxt_s = port1_rev_in & s_rev & s_use;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      p0_ff <= '0;
      p1_ff <= '0;
      g_ff <= '0;
      s_ff <= '0;
    end else begin
      p0_ff <= nxt_p0;
      p1_ff <= nxt_p1;
      g_ff <= nxt_g;
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire [7:0] rd_mux =
    (reg_addr == bccc_pkg::ADDR_CAP_ONE) ? {1'b0, mode_low_ff, 6'h00} :
    (reg_addr == bccc_pkg::ADDR_CAP_TWO) ?
      {4'h0, crc_ff, chk_err_ff, fast_ctrl_mode_upper_ff} :
    (reg_addr == bccc_pkg::ADDR_RATE_SEL) ? {5'h00, rate_dbl_ff, 2'b00} :
    (reg_addr == bccc_pkg::ADDR_OSC_DIV) ? {4'h0, osc_div_ff} :
    (reg_addr == bccc_pkg::ADDR_CTRL) ? {4'h0, ctrl_ff} :
    (reg_addr == bccc_pkg::ADDR_DIR) ? dir_ff :
    (reg_addr == bccc_pkg::ADDR_STATUS) ?
      {5'h00, single_link, odd_bad, code_ok} : 8'h00;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = rdata_ff;
  assign fast_mode_code = eff_code;
  assign fast_mode_ok = code_ok;
  assign enhanced_crc_enable = crc_ff;
  assign back_bit_tick = tick_ff;
  assign back_rate_bad = odd_bad;
  assign port0_fwd_out = p0_ff;
  assign port1_fwd_out = p1_ff;
  assign gpio_pin_out = g_ff;
  assign gpio_pin_oe = g_rev;
  assign sec_gpio_pin_out = s_ff;
  assign sec_gpio_pin_oe = s_rev & s_use;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_crc_reg_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_cap2 && !link_load |=> enhanced_crc_enable == $past(reg_wdata[3]))
    else $error("crc enable not written");
  a_chk_sticky: assert property (@(posedge clk) disable iff (!resetn)
    pixel_sum_bad && chk_enable |=> chk_err_ff)
    else $error("checksum flag not set");
  a_chk_gated: assert property (@(posedge clk) disable iff (!resetn)
    !chk_enable |=> !chk_err_ff)
    else $error("checksum flag set while disabled");
  a_mode_rsvd: assert property (@(posedge clk) disable iff (!resetn)
    code_rsvd |-> !fast_mode_ok && fast_mode_code == 3'h0)
    else $error("reserved mode accepted");
  a_single_link: assert property (@(posedge clk) disable iff (!resetn)
    single_link |-> fast_mode_code == 3'h0)
    else $error("fast mode on single link");
  a_tick_period: assert property (@(posedge clk) disable iff (!resetn)
    back_bit_tick && !cfg_chg && !rate_dbl_ff && !back_fast_mode && osc_div_ff == 4'h9
    |-> ##40 (back_bit_tick || cfg_now != $past(cfg_now, 40)))
    else $error("default rate period wrong");
  a_link_load: assert property (@(posedge clk) disable iff (!resetn)
    link_load |=> raw_code[2:1] == $past(cap_two_in[1:0]) && raw_code[0] == $past(cap_one_in[6]))
    else $error("capabilities not loaded");
  a_hold_keeps: assert property (@(posedge clk) disable iff (!resetn)
    cap_load && hold_caps && !reg_wr |=> $stable(raw_code))
    else $error("hold did not protect fields");
  a_div_reload: assert property (@(posedge clk) disable iff (!resetn)
    cfg_chg |=> !back_bit_tick ##1 cnt_ff == $past(period, 1) - 6'h02)
    else $error("divider not reloaded");
  a_sec_mask: assert property (@(posedge clk) disable iff (!resetn)
    eff_code == 3'h1 |-> sec_gpio_pin_oe[NSIG-1:1] == '0)
    else $error("restricted pins driven");
  c_fast_four: cover property (@(posedge clk) fast_mode_code == 3'h3);
  c_chk_flag: cover property (@(posedge clk) chk_err_ff);
  c_fast_tick: cover property (@(posedge clk) back_fast_mode && back_bit_tick);
  c_split_rev: cover property (@(posedge clk) |sec_gpio_pin_oe);

endmodule // bccc_regs

// ### sim/bccc_deser_model.sv
// Purpose: Remote deserializer side of the capability link
// Assumes: Bench calls the tasks between clock edges
// Notes: Bytes invert once the load strobe drops
`timescale 1ns/1ps
module bccc_deser_model (
  input wire logic clk,
  output logic rx_lock,
  output logic cap_load,
  output logic [7:0] cap_one_in,
  output logic [7:0] cap_two_in,
  output logic [3:0] port0_rev_in,
  output logic [3:0] port1_rev_in
);
  // ----------------------------------------
  // Capability delivery
  // ----------------------------------------
  initial begin
    rx_lock = 1'b0;
    cap_load = 1'b0;
    cap_one_in = 8'h00;
    cap_two_in = 8'h00;
    port0_rev_in = 4'h0;
    port1_rev_in = 4'h0;
  end
  // Bytes valid only with the strobe
  task automatic send_caps(input logic [7:0] one, input logic [7:0] two);
    @(posedge clk);
    rx_lock <= 1'b1;
    cap_load <= 1'b1;
    cap_one_in <= one;
    cap_two_in <= two;
    @(posedge clk);
    cap_load <= 1'b0;
    cap_one_in <= ~one;
    cap_two_in <= ~two;
  endtask
  // Same direction setup as the near end
  task automatic set_rev(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk);
    port0_rev_in <= a;
    port1_rev_in <= b;
  endtask
endmodule // bccc_deser_model

// ### sim/back_channel_cap_config_tb.sv
// Purpose: Self-checking bench for the capability and rate block
// Assumes: Register port with read data one cycle after the strobe
// Notes: Bit period is 4N, 2N or N clocks
`timescale 1ns/1ps
module back_channel_cap_config_tb;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic single_link = 1'b0, pixel_sum_bad = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd;
  logic [3:0] gin = 4'h0, sin = 4'h0, p0f, p1f, gout, goe, sout, soe, p0r, p1r;
  logic [2:0] code;
  logic ok, crc, tick, bad, lock, cload;
  logic [7:0] c1, c2, expv;
  int n_mismatch = 0, n_tests = 0, n;
  initial forever #25 clk = ~clk;
  bccc_deser_model bccc_deser_model_i (.clk(clk), .rx_lock(lock), .cap_load(cload),
    .cap_one_in(c1), .cap_two_in(c2), .port0_rev_in(p0r), .port1_rev_in(p1r));
  bccc_regs bccc_regs_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .single_link(single_link), .rx_lock(lock), .cap_load(cload), .cap_one_in(c1),
    .cap_two_in(c2), .pixel_sum_bad(pixel_sum_bad), .gpio_pin_in(gin),
    .sec_gpio_pin_in(sin), .port0_rev_in(p0r), .port1_rev_in(p1r),
    .port0_fwd_out(p0f), .port1_fwd_out(p1f), .gpio_pin_out(gout), .gpio_pin_oe(goe),
    .sec_gpio_pin_out(sout), .sec_gpio_pin_oe(soe), .fast_mode_code(code),
    .fast_mode_ok(ok), .enhanced_crc_enable(crc), .back_bit_tick(tick),
    .back_rate_bad(bad));
  // ----------------------------------------
  // Bus, compare, period and closing tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic period(output int p);
    p = 0;
    // Skip the edge that reloads the divider after a write
    @(posedge clk);
    #1;
    for (int i = 0; i < 300 && tick !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    do begin
      @(posedge clk);
      #1;
      p++;
    end while (tick !== 1'b1 && p < 300);
  endtask
  task automatic conclude;
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    conclude();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rdr(8'h32);
    chk("div reset", 8'h09, rd & 8'h0F);
    rdr(8'h21);
    chk("cap2 reset", 8'h00, rd);
    period(n);
    chk("reset period", 8'd40, n[7:0]);
    rdr(8'h7F);
    chk("unmapped", 8'h00, rd);
    $display("test reset done");
    wr(8'h21, 8'hFF);
    chk("crc out", 8'h01, {7'h0, crc});
    rdr(8'h21);
    chk("cap2 rw", 8'h0B, rd);
    for (int c = 0; c < 8; c++) begin
      wr(8'h20, {1'b0, c[0], 6'h00});
      wr(8'h21, {6'h00, c[2:1]});
      expv = (c == 4 || c == 5) ? 8'h00 : {4'h0, 1'b1, c[2:0]};
      chk("mode", expv, {4'h0, ok, code});
    end
    @(posedge clk);
    single_link <= 1'b1;
    wr(8'h20, 8'h40);
    wr(8'h21, 8'h00);
    chk("single link", 8'h00, {5'h0, code});
    rdr(8'h42);
    chk("status", 8'h04, rd);
    @(posedge clk);
    single_link <= 1'b0;
    $display("test modes done");
    wr(8'h32, 8'h01);
    period(n);
    chk("n2 base", 8'd8, n[7:0]);
    wr(8'h23, 8'h04);
    period(n);
    chk("n2 double", 8'd4, n[7:0]);
    wr(8'h40, 8'h01);
    period(n);
    chk("n2 fast", 8'd2, n[7:0]);
    chk("even ok", 8'h00, {7'h0, bad});
    wr(8'h32, 8'h02);
    chk("odd bad", 8'h01, {7'h0, bad});
    wr(8'h40, 8'h00);
    wr(8'h23, 8'h00);
    wr(8'h32, 8'h0F);
    period(n);
    chk("n16 base", 8'd64, n[7:0]);
    wr(8'h32, 8'h09);
    $display("test rate done");
    wr(8'h40, 8'h08);
    @(posedge clk);
    pixel_sum_bad <= 1'b1;
    @(posedge clk);
    pixel_sum_bad <= 1'b0;
    rdr(8'h21);
    chk("sum err set", 8'h04, rd & 8'h04);
    wr(8'h40, 8'h00);
    @(posedge clk);
    pixel_sum_bad <= 1'b1;
    @(posedge clk);
    pixel_sum_bad <= 1'b0;
    rdr(8'h21);
    chk("sum err off", 8'h00, rd & 8'h04);
    $display("test checksum done");
    bccc_deser_model_i.send_caps(8'h40, 8'h03);
    #1;
    chk("cap load", 8'h07, {5'h0, code});
    wr(8'h40, 8'h04);
    bccc_deser_model_i.send_caps(8'h00, 8'h00);
    #1;
    chk("cap hold", 8'h07, {5'h0, code});
    $display("test link load done");
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h40, 8'h02);
    wr(8'h41, 8'h00);
    @(posedge clk);
    gin <= 4'hA;
    sin <= 4'h5;
    repeat (2) @(posedge clk);
    #1;
    chk("port0 fwd", 8'h0A, {4'h0, p0f});
    chk("port1 fwd", 8'h05, {4'h0, p1f});
    chk("fwd oe", 8'h00, {4'h0, goe});
    wr(8'h41, 8'hFF);
    bccc_deser_model_i.set_rev(4'h6, 4'h9);
    repeat (2) @(posedge clk);
    #1;
    chk("rev out", 8'h69, {gout, sout});
    chk("rev fwd", 8'h00, {p0f, p1f});
    chk("rev oe", 8'h0F, {4'h0, goe});
    chk("sec rev oe", 8'h0F, {4'h0, soe});
    wr(8'h41, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h20, 8'h40);
    @(posedge clk);
    sin <= 4'hF;
    repeat (2) @(posedge clk);
    #1;
    chk("one sig mask", 8'h01, {4'h0, p1f});
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    chk("two sig mask", 8'h03, {4'h0, p1f});
    $display("test routing done");
    conclude();
  end
endmodule // back_channel_cap_config_tb
